// *** src/boundary_scan_tap.sv ***
// boundary scan test access port with its observation log fifo
`timescale 1ns/10ps
`include "tap_params.svh"

module scan_log_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = `LOG_DEPTH
) (
    input  wire logic         core_clk,  // system clock
    input  wire logic         rst,       // synchronous reset
    input  wire logic         in_valid,  // word offered
    output logic              in_ready,  // room for a word
    input  wire logic [W-1:0] in_data,   // word in
    output logic              out_valid, // word waiting
    input  wire logic         out_ready, // reader takes word
    output logic [W-1:0]      out_data   // oldest word
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    // handshakes and occupancy
    assign push  = in_valid && in_ready;
    assign pop   = out_valid && out_ready;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign rd_d  = pop ? rd_q + 1'h1 : rd_q;

    // pointers and flags; flags are registered so ports come from flops
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wr_q      <= '0;
            rd_q      <= '0;
            cnt_q     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            wr_q      <= push ? wr_q + 1'b1 : wr_q;
            rd_q      <= rd_d;
            cnt_q     <= cnt_d;
            in_ready  <= cnt_d != (AW+1)'(DEPTH);
            out_valid <= cnt_d != '0;
        end
    end

    // storage and registered head; a push into the head slot bypasses
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
        out_data <= (push && wr_q == rd_d) ? in_data : mem[rd_d];
    end
endmodule

module boundary_scan_tap #(
    parameter int             NUM_IO   = 4,
    parameter int             LOG_DEPTH = `LOG_DEPTH,
    parameter logic [3:0]     VERSION  = 4'h1,    // arbitrary value
    parameter logic [15:0]    PART_NUM = 16'h0001, // arbitrary value
    parameter logic [10:0]    MAKER_ID = 11'h001   // arbitrary value
) (
    input  wire logic               core_clk,  // system clock, 40 MHz
    input  wire logic               rst,       // power-up reset, active high
    input  wire logic               trst_n,    // test reset pin, async
    input  tap_pkg::jtag_pins_t     jtag,      // tck, tms, tdi pins
    output logic                    tdo,       // test data out
    output logic                    tdo_oe,    // high while tdo is driven
    input  wire logic [NUM_IO-1:0]  core_out,  // core wants these levels
    input  wire logic [NUM_IO-1:0]  core_oe,   // core wants these enables
    output logic [NUM_IO-1:0]       core_in,   // pin levels seen by core
    input  wire logic [NUM_IO-1:0]  pin_in,    // pad input levels
    output logic [NUM_IO-1:0]       pin_out,   // pad output levels
    output logic [NUM_IO-1:0]       pin_oe,    // pad output enables
    output logic                    log_space, // log can take a word
    output logic                    log_valid, // logged word waiting
    input  wire logic               log_ready, // reader takes the word
    output logic [3*NUM_IO-1:0]     log_data   // boundary word updated
);
    localparam int BW = `CELLS_PER_IO * NUM_IO;
    localparam int SW = NUM_IO + 3;

    tap_pkg::tap_state_t state_q, state_d;
    tap_pkg::dr_sel_t    dr_sel;
    logic [SW-1:0] meta_q, sync_q;
    logic          tck_s, tms_s, tdi_s, tck_prev_q, tck_rise, tck_fall;
    logic [NUM_IO-1:0] pin_in_s;
    logic [`IR_WIDTH-1:0] ir_q, ir_sh_q;
    logic          byp_q;
    logic [`ID_WIDTH-1:0] id_sh_q, id_value;
    logic [BW-1:0] bsr_sh_q, bsr_upd_q, bsr_cap;
    logic [NUM_IO-1:0] upd_in, upd_out, upd_oe;
    logic          extest, dr_bit, log_push;

    // next state of the controller from the sampled mode level
    function automatic tap_pkg::tap_state_t next_state(
        input tap_pkg::tap_state_t s,
        input logic                m
    );
        case (s)
            tap_pkg::TLR:    next_state = m ? tap_pkg::TLR    : tap_pkg::RTI;
            tap_pkg::RTI:    next_state = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_DR: next_state = m ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
            tap_pkg::CAP_DR: next_state = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::SH_DR:  next_state = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::EX1_DR: next_state = m ? tap_pkg::UPD_DR : tap_pkg::PA_DR;
            tap_pkg::PA_DR:  next_state = m ? tap_pkg::EX2_DR : tap_pkg::PA_DR;
            tap_pkg::EX2_DR: next_state = m ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
            tap_pkg::UPD_DR: next_state = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_IR: next_state = m ? tap_pkg::TLR    : tap_pkg::CAP_IR;
            tap_pkg::CAP_IR: next_state = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::SH_IR:  next_state = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::EX1_IR: next_state = m ? tap_pkg::UPD_IR : tap_pkg::PA_IR;
            tap_pkg::PA_IR:  next_state = m ? tap_pkg::EX2_IR : tap_pkg::PA_IR;
            tap_pkg::EX2_IR: next_state = m ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
            tap_pkg::UPD_IR: next_state = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
            default:         next_state = tap_pkg::TLR;
        endcase
    endfunction

    // instruction decode, used for the path mux and the log push; the pin mode compares ir_q on its own
    function automatic tap_pkg::dr_sel_t decode_dr(
        input logic [`IR_WIDTH-1:0] ir
    );
        if (ir == `OP_IDCODE)
            decode_dr = tap_pkg::SEL_ID;
        else if (ir == `OP_EXTEST || ir == `OP_SAMPLE)
            decode_dr = tap_pkg::SEL_BSR;
        else
            decode_dr = tap_pkg::SEL_BYP;
    endfunction

    // two flops on every pin except trst_n before logic looks at it
    always_ff @(posedge core_clk)
    begin
        meta_q     <= {jtag.tck, jtag.tms, jtag.tdi, pin_in};
        sync_q     <= meta_q;
        tck_prev_q <= tck_s;
    end

    assign {tck_s, tms_s, tdi_s, pin_in_s} = sync_q;
    // edges of the test clock found by the core clock; the tester clock
    // must stay well below a quarter of core_clk for this to hold
    assign tck_rise = tck_s && !tck_prev_q;
    assign tck_fall = !tck_s && tck_prev_q;

    // controller state; trst_n clears it without any clock edge
    always_ff @(posedge core_clk or negedge trst_n)
    begin
        if (!trst_n)
            state_q <= tap_pkg::TLR;
        else if (rst)
            state_q <= tap_pkg::TLR;
        else
            state_q <= state_d;
    end
    assign state_d = tck_rise ? next_state(state_q, tms_s)
                              : state_q;

    // selection of the data register and of the pin mode
    assign dr_sel = decode_dr(ir_q);
    assign extest = ir_q == `OP_EXTEST;
    assign id_value = {VERSION, PART_NUM, MAKER_ID, 1'b1};
    assign dr_bit = dr_sel == tap_pkg::SEL_ID  ? id_sh_q[0]
                  : dr_sel == tap_pkg::SEL_BSR ? bsr_sh_q[0]
                  : byp_q;
    assign log_push = tck_fall && state_q == tap_pkg::UPD_DR
                      && dr_sel == tap_pkg::SEL_BSR;

    // three cells per pin: input, output and enable, each with taps
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IO; gi++)
        begin : g_cell
            assign bsr_cap[3*gi+`CELL_IN]  = pin_in_s[gi];
            assign bsr_cap[3*gi+`CELL_OUT] = core_out[gi];
            assign bsr_cap[3*gi+`CELL_OE]  = core_oe[gi];
            assign upd_in[gi]  = bsr_upd_q[3*gi+`CELL_IN];
            assign upd_out[gi] = bsr_upd_q[3*gi+`CELL_OUT];
            assign upd_oe[gi]  = bsr_upd_q[3*gi+`CELL_OE];
        end
    endgenerate

    // instruction register: capture, shift on rise, update on fall
    always_ff @(posedge core_clk or negedge trst_n)
    begin
        if (!trst_n)
        begin
            ir_q    <= `OP_IDCODE;
            ir_sh_q <= `IR_CAPTURE;
        end
        else if (rst || state_q == tap_pkg::TLR)
            ir_q    <= `OP_IDCODE;
        else if (tck_rise && state_q == tap_pkg::CAP_IR)
            ir_sh_q <= `IR_CAPTURE;
        else if (tck_rise && state_q == tap_pkg::SH_IR)
            ir_sh_q <= {tdi_s, ir_sh_q[`IR_WIDTH-1:1]};
        else if (tck_fall && state_q == tap_pkg::UPD_IR)
            ir_q    <= ir_sh_q;
    end

    // data registers: only the selected one shifts; bypass clears on every capture
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            byp_q    <= 1'b0;
            id_sh_q  <= '0;
            bsr_sh_q <= '0;
        end
        else if (tck_rise && state_q == tap_pkg::CAP_DR)
        begin
            byp_q    <= 1'b0;
            id_sh_q  <= (dr_sel == tap_pkg::SEL_ID) ? id_value : id_sh_q;
            bsr_sh_q <= (dr_sel == tap_pkg::SEL_BSR) ? bsr_cap : bsr_sh_q;
        end
        else if (tck_rise && state_q == tap_pkg::SH_DR)
        begin
            byp_q    <= (dr_sel == tap_pkg::SEL_BYP) ? tdi_s : byp_q;
            id_sh_q  <= (dr_sel == tap_pkg::SEL_ID)
                        ? {tdi_s, id_sh_q[`ID_WIDTH-1:1]} : id_sh_q;
            bsr_sh_q <= (dr_sel == tap_pkg::SEL_BSR)
                        ? {tdi_s, bsr_sh_q[BW-1:1]} : bsr_sh_q;
        end
    end

    // boundary update latch, written on the falling edge of update
    always_ff @(posedge core_clk)
    begin
        if (rst)
            bsr_upd_q <= '0;
        else if (log_push)
            bsr_upd_q <= bsr_sh_q;
    end

    // test output changes on falling edges and floats outside shifting
    always_ff @(posedge core_clk or negedge trst_n)
    begin
        if (!trst_n)
        begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (rst)
        begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo    <= (state_q == tap_pkg::SH_IR) ? ir_sh_q[0] : dr_bit;
            tdo_oe <= state_q == tap_pkg::SH_IR
                      || state_q == tap_pkg::SH_DR;
        end
    end

    // pin side: extest hands the pads to the scan cells
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pin_out <= '0;
            pin_oe  <= '0;
            core_in <= '0;
        end
        else
        begin
            pin_out <= extest ? upd_out : core_out;
            pin_oe  <= extest ? upd_oe : core_oe;
            core_in <= extest ? upd_in : pin_in_s;
        end
    end

    // every boundary update is logged; a full log drops the word and
    // shows it on log_space, since the tester's clock cannot be held
    scan_log_fifo #(
        .W     (BW),
        .DEPTH (LOG_DEPTH)
    ) u_log (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (log_push),
        .in_ready  (log_space),
        .in_data   (bsr_sh_q),
        .out_valid (log_valid),
        .out_ready (log_ready),
        .out_data  (log_data)
    );

    // checks on the controller and the registers
    logic [2:0] ones_cnt_q;
    always_ff @(posedge core_clk)
    begin
        if (rst || (tck_rise && !tms_s))
            ones_cnt_q <= '0;
        else if (tck_rise && ones_cnt_q != 3'h5)
            ones_cnt_q <= ones_cnt_q + 3'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst || !trst_n);

    a_power_up_reset: assert property (disable iff (!trst_n)
        rst |=> state_q == tap_pkg::TLR) else $error("no reset state");
    a_trst_forces: assert property (disable iff (rst)
        !trst_n |-> state_q == tap_pkg::TLR) else $error("trst ignored");
    a_tms_edge_only: assert property (
        !tck_rise |=> $stable(state_q)) else $error("move without edge");
    a_five_ones_reset: assert property (
        ones_cnt_q == 3'h5 |-> state_q == tap_pkg::TLR)
        else $error("five ones did not reset");
    a_bypass_capture: assert property (
        tck_rise && state_q == tap_pkg::CAP_DR && dr_sel == tap_pkg::SEL_BYP
        |=> !byp_q) else $error("bypass capture not zero");
    a_id_capture: assert property (
        tck_rise && state_q == tap_pkg::CAP_DR && dr_sel == tap_pkg::SEL_ID
        |=> id_sh_q == id_value && id_sh_q[`ID_LSB])
        else $error("wrong identification");
    a_ir_update: assert property (
        tck_fall && state_q == tap_pkg::UPD_IR |=> ir_q == $past(ir_sh_q))
        else $error("instruction not updated");
    a_bsr_update: assert property (
        log_push |=> bsr_upd_q == $past(bsr_sh_q) ##2 !extest
        || pin_out == upd_out) else $error("boundary update lost");
    a_tdo_enable: assert property (
        tck_fall |=> tdo_oe == (state_q == tap_pkg::SH_DR
        || state_q == tap_pkg::SH_IR)) else $error("tdo enable wrong");
    a_ir_capture: assert property (
        tck_rise && state_q == tap_pkg::CAP_IR |=> ir_sh_q == `IR_CAPTURE)
        else $error("instruction capture wrong");

    c_shift_dr: cover property (tck_rise && state_q == tap_pkg::SH_DR);
    c_ir_update: cover property (tck_fall && state_q == tap_pkg::UPD_IR);
    c_log_full: cover property (log_push && !log_space);
    c_five_ones: cover property (ones_cnt_q == 3'h5);
endmodule

// *** src/tap_params.svh ***
// constants for the boundary scan test access port
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH
`define IR_WIDTH     4
`define OP_EXTEST    4'h0
`define OP_SAMPLE    4'h1
`define OP_IDCODE    4'h2
`define OP_BYPASS    4'hF
`define IR_CAPTURE   4'h1
`define ID_WIDTH     32
`define ID_LSB       0
`define ID_MAKER_LO  1
`define ID_PART_LO   12
`define ID_VER_LO    28
`define CELLS_PER_IO 3
`define CELL_IN      0
`define CELL_OUT     1
`define CELL_OE      2
`define LOG_DEPTH    16
`endif

// *** src/tap_pkg.sv ***
// types shared by the boundary scan test access port
package tap_pkg;
    // controller states, four bits, sixteen states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;
    // data register chosen by the current instruction
    typedef enum logic [1:0] {SEL_BYP, SEL_ID, SEL_BSR} dr_sel_t;
    // the test pins that arrive from the tester
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jtag_pins_t;
endpackage

// *** sim/jtag_tester.sv ***
// tester model that drives the test pins of the scan port
`timescale 1ns/10ps

module jtag_tester (
    input  wire logic           core_clk, // system clock, paces the pins
    output tap_pkg::jtag_pins_t jtag,     // tck, tms, tdi to the port
    input  wire logic           tdo,      // test data from the port
    input  wire logic           tdo_oe    // high while tdo is driven
);
    initial jtag = '0;

    // one tck period of 8 core clocks, 4 low then 4 high; tck rests low
    // between calls so the link clock stands still outside frames
    task automatic clk_bit(input logic m, input logic d,
                           output logic q, output logic oe);
    begin
        @(posedge core_clk);
        jtag.tms <= m; // set while tck is low
        jtag.tdi <= d;
        repeat (3) @(posedge core_clk);
        jtag.tck <= 1'h1; // mode and data held across the rise
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        // late in the high phase; a released line reads inverted here
        q  = tdo_oe ? tdo : ~tdo;
        oe = tdo_oe;
        @(posedge core_clk);
        jtag.tck <= 1'h0;
        jtag.tdi <= ~d; // data line carries no meaning after the rise
    end
    endtask

    // guaranteed reset from any state, then park in idle
    task automatic tap_reset;
        logic q;
        logic oe;
    begin
        repeat (5) clk_bit(1'h1, 1'h0, q, oe); // five highs
        clk_bit(1'h0, 1'h0, q, oe);
    end
    endtask
endmodule

// *** sim/boundary_scan_tap_tb_top.sv ***
// self-checking bench for the boundary scan port and its log fifo
`timescale 1ns/10ps
`include "tap_params.svh"

module boundary_scan_tap_tb_top;
    localparam logic [31:0] id_word = {4'hA, 16'h5A3C, 11'h2B5, 1'h1};
    logic                core_clk  = 1'h0;
    logic                rst       = 1'h1;
    logic                trst_n    = 1'h1;
    logic                log_ready = 1'h0;
    logic [3:0]          core_out  = 4'h0;
    logic [3:0]          core_oe   = 4'h0;
    logic [3:0]          pin_in    = 4'h0;
    tap_pkg::jtag_pins_t jtag;
    logic                tdo;
    logic                tdo_oe;
    logic                log_space;
    logic                log_valid;
    logic [3:0]          core_in;
    logic [3:0]          pin_out;
    logic [3:0]          pin_oe;
    logic [11:0]         log_data;
    int                  num_errors   = 0;
    int                  total_checks = 0;

    always #12.5 core_clk = ~core_clk;

    // identity values are arbitrary
    boundary_scan_tap #(.NUM_IO(4), .LOG_DEPTH(16), .VERSION(4'hA),
        .PART_NUM(16'h5A3C), .MAKER_ID(11'h2B5)) DUT (
        .core_clk(core_clk), .rst(rst), .trst_n(trst_n), .jtag(jtag),
        .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out),
        .core_oe(core_oe), .core_in(core_in), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .log_space(log_space),
        .log_valid(log_valid), .log_ready(log_ready),
        .log_data(log_data));

    jtag_tester tester (.core_clk(core_clk), .jtag(jtag), .tdo(tdo),
        .tdo_oe(tdo_oe));

    task automatic test_done;
    begin
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    begin
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    // one field of every pin's three cells: 0 input, 1 output, 2 enable
    function automatic logic [3:0] pick(input logic [11:0] w, input int f);
        for (int i = 0; i < 4; i++)
            pick[i] = w[3 * i + f];
    endfunction

    function automatic logic [11:0] wd(input int k);
        return 12'h0A5 + 12'(k) * 12'h149;
    endfunction

    // idle, select, capture, n shift bits lsb first, update, idle
    task automatic scan(input logic ir, input int n,
                        input logic [31:0] din, output logic [31:0] dout);
        logic        q;
        logic        oe;
        logic [31:0] oes;
    begin
        dout = '0;
        oes  = '0;
        tester.clk_bit(1'h1, 1'h0, q, oe);
        if (ir)
            tester.clk_bit(1'h1, 1'h0, q, oe);
        repeat (2) tester.clk_bit(1'h0, 1'h0, q, oe);
        for (int i = 0; i < n; i++)
        begin
            tester.clk_bit(i == n - 1, din[i], q, oe);
            dout[i] = q;
            oes[i]  = oe;
        end
        tester.clk_bit(1'h1, 1'h0, q, oe);
        check("tdo_oe after shift", 32'h0, 32'(oe));
        tester.clk_bit(1'h0, 1'h0, q, oe);
        check("tdo_oe in shift", (32'h1 << n) - 32'h1, oes);
    end
    endtask

    task automatic t_idcode;
        logic        q;
        logic        oe;
        logic [31:0] d;
    begin
        tester.clk_bit(1'h0, 1'h0, q, oe);
        scan(1'h0, 32, 32'h0, d);
        check("idcode at power-up", id_word, d);
        $display("test idcode done");
    end
    endtask

    // plain bypass and an unassigned opcode both give a one-bit path
    task automatic t_bypass;
        logic [31:0] d;
    begin
        for (int k = 0; k < 2; k++)
        begin
            scan(1'h1, 4, (k == 0) ? 32'(`OP_BYPASS) : 32'h7, d);
            check("ir capture", 32'(`IR_CAPTURE), d);
            scan(1'h0, 8, 32'hA5, d);
            check("bypass path", 32'h4A, d);
        end
        $display("test bypass done");
    end
    endtask

    task automatic t_sample;
        logic [31:0] d;
    begin
        pin_in   <= 4'h9;
        core_out <= 4'h5;
        core_oe  <= 4'h3;
        scan(1'h1, 4, 32'(`OP_SAMPLE), d);
        scan(1'h0, 12, 32'h0, d);
        check("input cells", 32'h9, 32'(pick(d[11:0], 0)));
        check("output cells", 32'h5, 32'(pick(d[11:0], 1)));
        check("enable cells", 32'h3, 32'(pick(d[11:0], 2)));
        check("pins functional", 32'h35, 32'({pin_oe, pin_out}));
        check("core sees pads", 32'h9, 32'(core_in));
        $display("test sample done");
    end
    endtask

    // extest updates fill the log while the reader stalls, then drain
    task automatic t_fifo;
        logic [31:0] d;
        logic [11:0] w;
    begin
        log_ready <= 1'h1;
        repeat (4) @(posedge core_clk);
        log_ready <= 1'h0;
        scan(1'h1, 4, 32'(`OP_EXTEST), d);
        for (int k = 0; k < 17; k++)
        begin
            scan(1'h0, 12, 32'(wd(k)), d);
            if (k == 15)
                check("log full", 32'h0, 32'(log_space));
        end
        w = wd(16);
        check("pin levels", 32'(pick(w, 1)), 32'(pin_out));
        check("pin enables", 32'(pick(w, 2)), 32'(pin_oe));
        check("core inputs", 32'(pick(w, 0)), 32'(core_in));
        @(posedge core_clk);
        log_ready <= 1'h1;
        for (int k = 0; k < 16; k++)
        begin
            @(negedge core_clk);
            check("log word", 32'(wd(k)), 32'(log_data));
            @(posedge core_clk);
        end
        log_ready <= 1'h0;
        @(negedge core_clk);
        check("log drained", 32'h0, 32'(log_valid));
        $display("test fifo done");
    end
    endtask

    // shift with a pause half way, back through exit2 into shift
    task automatic scan_pause(input logic ir, input int n,
                              input logic [31:0] din,
                              output logic [31:0] dout);
        logic q;
        logic oe;
    begin
        dout = '0;
        tester.clk_bit(1'h1, 1'h0, q, oe);
        if (ir)
            tester.clk_bit(1'h1, 1'h0, q, oe);
        repeat (2) tester.clk_bit(1'h0, 1'h0, q, oe);
        for (int i = 0; i < n; i++)
        begin
            tester.clk_bit(i == n / 2 - 1 || i == n - 1, din[i], q, oe);
            dout[i] = q;
            if (i == n / 2 - 1)
            begin
                repeat (2) tester.clk_bit(1'h0, 1'h0, q, oe);
                check("tdo_oe in pause", 32'h0, 32'(oe));
                tester.clk_bit(1'h1, 1'h0, q, oe);
                tester.clk_bit(1'h0, 1'h0, q, oe);
            end
        end
        tester.clk_bit(1'h1, 1'h0, q, oe);
        tester.clk_bit(1'h0, 1'h0, q, oe);
    end
    endtask

    // load identification through the pause states, read it the same way
    task automatic t_pause;
        logic [31:0] d;
    begin
        scan_pause(1'h1, 4, 32'(`OP_IDCODE), d);
        check("ir capture paused", 32'(`IR_CAPTURE), d);
        scan_pause(1'h0, 32, 32'h0, d);
        check("idcode paused", id_word, d);
        $display("test pause done");
    end
    endtask

    // leave shift-dr under bypass by five highs, then by the reset pin
    task automatic t_resets;
        logic        q;
        logic        oe;
        logic [31:0] d;
    begin
        for (int k = 0; k < 2; k++)
        begin
            scan(1'h1, 4, 32'(`OP_BYPASS), d);
            tester.clk_bit(1'h1, 1'h0, q, oe);
            repeat (3) tester.clk_bit(1'h0, 1'h0, q, oe);
            check("tdo_oe shifting", 32'h1, 32'(oe));
            if (k == 0)
                tester.tap_reset();
            else
            begin
                trst_n <= 1'h0;
                #2;
                check("tdo_oe on trst", 32'h0, 32'(tdo_oe));
                @(posedge core_clk);
                trst_n <= 1'h1;
                repeat (3) @(posedge core_clk);
                tester.clk_bit(1'h0, 1'h0, q, oe);
            end
            scan(1'h0, 32, 32'h0, d);
            check("idcode after reset", id_word, d);
        end
        $display("test resets done");
    end
    endtask

    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        t_idcode();
        t_bypass();
        t_sample();
        t_fifo();
        t_pause();
        t_resets();
        test_done();
    end

    // the tests need roughly 4600 clocks
    initial
    begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        $display("watchdog expired");
        test_done();
    end
endmodule
